// ---- qadc_top.sv ----
// Quad converter configuration registers and output framing
`timescale 1ns/1ps
module qadc_top (
  // Clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // Serial configuration pins
  input wire logic sen_n_i,
  input wire logic sclk_i,
  input wire logic sdata_i,
  output logic sdout_o,
  output logic sdout_oe_o,
  // Enhancement select pin
  input wire logic enhance_select_pin_i,
  // Raw converter codes, offset binary, all channels
  input wire logic [qadc_pkg::WORD_BITS-1:0] core_code_i,
  // Analog control outputs
  output logic enhance_en_o,
  output logic [qadc_pkg::NUM_CHAN-1:0] power_off_o,
  output logic [3:0] low_clock_trim_group_o,
  // Double-rate output lanes
  output logic [qadc_pkg::LANE_BITS-1:0] dout_o,
  output logic dout_valid_o,
  output logic dout_phase_o,
  input wire logic rx_ready_i
);
  import qadc_pkg::*;

  qadc_reg_if rif ();

  // Serial slave
  qadc_spi u_spi (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .sen_n_i(sen_n_i),
    .sclk_i(sclk_i),
    .sdata_i(sdata_i),
    .sdout_o(sdout_o),
    .sdout_oe_o(sdout_oe_o),
    .bus(rif.master)
  );

  // Register bank state
  logic [7:0] snr_control_source_select, next_src; // Override register
  logic [7:0] channel_power_down, next_pwr; // Power-down register
  logic [3:0] trim, next_trim; // Trim bits 14..17
  logic enh_dis, next_enh_dis; // Enhancement disable bit

  // Register write decode
  always_comb begin
    next_src = snr_control_source_select;
    next_pwr = channel_power_down;
    next_trim = trim;
    next_enh_dis = enh_dis;
    if (rif.wr) begin
      // Reserved bits of the source and power registers are stored as written; host keeps them zero
      case (rif.addr)
        ADDR_SRC_SEL: next_src = rif.wdata;
        ADDR_PWR: next_pwr = rif.wdata;
        ADDR_ENH_DIS: next_enh_dis = rif.wdata[ENH_DIS_BIT];
        ADDR_TRIM14: next_trim[0] = rif.wdata[TRIM_BIT];
        ADDR_TRIM15: next_trim[1] = rif.wdata[TRIM_BIT];
        ADDR_TRIM16: next_trim[2] = rif.wdata[TRIM_BIT];
        ADDR_TRIM17: next_trim[3] = rif.wdata[TRIM_BIT];
        // Unmapped offsets, including tuning ones, are ignored
        default: next_trim = trim;
      endcase
    end
  end

  // Register bank, zero after reset
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      snr_control_source_select <= REG_RESET;
      channel_power_down <= REG_RESET;
      trim <= 4'h0;
      enh_dis <= 1'b0;
    end else begin
      snr_control_source_select <= next_src;
      channel_power_down <= next_pwr;
      trim <= next_trim;
      enh_dis <= next_enh_dis;
    end
  end

  // Read mux; unmapped offsets read zero
  always_comb begin
    case (rif.addr)
      ADDR_SRC_SEL: rif.rdata = snr_control_source_select;
      ADDR_PWR: rif.rdata = channel_power_down;
      ADDR_ENH_DIS: rif.rdata = {7'h00, enh_dis};
      ADDR_TRIM14: rif.rdata = {7'h00, trim[0]};
      ADDR_TRIM15: rif.rdata = {7'h00, trim[1]};
      ADDR_TRIM16: rif.rdata = {7'h00, trim[2]};
      ADDR_TRIM17: rif.rdata = {7'h00, trim[3]};
      default: rif.rdata = 8'h00;
    endcase
  end

  // Enhancement source: pin unless override is set
  assign enhance_en_o = snr_control_source_select[SRC_SEL_BIT] ? ~enh_dis
                                                               : enhance_select_pin_i;
  // Channel order in power_off_o is A, B, C, D from bit 0
  assign power_off_o[3] = channel_power_down[PWR_D_BIT];
  assign power_off_o[2] = channel_power_down[PWR_C_BIT];
  assign power_off_o[1] = channel_power_down[PWR_B_BIT];
  assign power_off_o[0] = channel_power_down[PWR_A_BIT];
  assign low_clock_trim_group_o = trim;

  // Sample clock is half the system clock; one enable every second cycle
  logic samp_ph, next_samp_ph;
  logic samp_en;
  assign samp_en = ~samp_ph;

  // Captured word, two's complement, powered-down channels read zero
  logic [WORD_BITS-1:0] cap_word;
  genvar ch;
  generate
    for (ch = 0; ch < NUM_CHAN; ch++) begin : g_chan
      // Flip the top bit to turn offset binary into two's complement
      assign cap_word[ch*RES_BITS +: RES_BITS] = power_off_o[ch] ? '0
        : {~core_code_i[ch*RES_BITS+RES_BITS-1], core_code_i[ch*RES_BITS +: RES_BITS-1]};
    end
  endgenerate

  // Latency pipeline, one stage per sample clock
  logic [WORD_BITS-1:0] pipe [LATENCY_CYC];
  logic [WORD_BITS-1:0] next_pipe [LATENCY_CYC];
  logic [LATENCY_CYC-1:0] pvld, next_pvld;
  logic buf_in_ready;
  logic adv;
  // A full buffer freezes the pipeline so no word is lost
  assign adv = samp_en & buf_in_ready;

  // Pipeline advance
  always_comb begin
    next_samp_ph = ~samp_ph;
    next_pipe = pipe;
    next_pvld = pvld;
    if (adv) begin
      // All four channels captured on the same enable
      next_pipe[0] = cap_word;
      next_pvld[0] = 1'b1;
      for (int i = 1; i < LATENCY_CYC; i++) begin
        next_pipe[i] = pipe[i-1];
        next_pvld[i] = pvld[i-1];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      samp_ph <= 1'b0;
      pvld <= '0;
      for (int i = 0; i < LATENCY_CYC; i++) begin
        pipe[i] <= '0;
      end
    end else begin
      samp_ph <= next_samp_ph;
      pipe <= next_pipe;
      pvld <= next_pvld;
    end
  end

  // Buffer between pipeline and lanes
  logic buf_out_valid;
  logic buf_out_ready;
  logic [WORD_BITS-1:0] buf_out_data;
  qadc_buf u_buf (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .in_valid_i(adv & pvld[LATENCY_CYC-1]),
    .in_ready_o(buf_in_ready),
    .in_data_i(pipe[LATENCY_CYC-1]),
    .out_valid_o(buf_out_valid),
    .out_ready_i(buf_out_ready),
    .out_data_o(buf_out_data)
  );

  // Double-rate serializer: phase 0 even bits, phase 1 odd bits
  logic [WORD_BITS-1:0] ser_word, next_ser_word;
  logic ser_busy, next_ser_busy; // Second half pending
  logic [LANE_BITS-1:0] lane, next_lane;
  logic lane_vld, next_lane_vld;
  logic lane_ph, next_lane_ph;
  logic [LANE_BITS-1:0] even_bits, odd_bits;
  logic [11:0] wpad [NUM_CHAN];
  logic [11:0] spad [NUM_CHAN];
  assign buf_out_ready = rx_ready_i & ~ser_busy;

  generate
    for (ch = 0; ch < NUM_CHAN; ch++) begin : g_lane
      assign wpad[ch] = {1'b0, buf_out_data[ch*RES_BITS +: RES_BITS]};
      assign spad[ch] = {1'b0, ser_word[ch*RES_BITS +: RES_BITS]};
      for (genvar b = 0; b < HALF_BITS; b++) begin : g_bit
        assign even_bits[ch*HALF_BITS+b] = wpad[ch][2*b];
        assign odd_bits[ch*HALF_BITS+b] = spad[ch][2*b+1];
      end
    end
  endgenerate

  // Serializer next state
  always_comb begin
    next_ser_word = ser_word;
    next_ser_busy = ser_busy;
    next_lane = lane;
    next_lane_vld = 1'b0;
    next_lane_ph = lane_ph;
    if (rx_ready_i) begin
      if (ser_busy) begin
        next_lane = odd_bits;
        next_lane_vld = 1'b1;
        next_lane_ph = 1'b1;
        next_ser_busy = 1'b0;
      end else if (buf_out_valid) begin
        next_lane = even_bits;
        next_lane_vld = 1'b1;
        next_lane_ph = 1'b0;
        next_ser_word = buf_out_data;
        next_ser_busy = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      ser_word <= '0;
      ser_busy <= 1'b0;
      lane <= '0;
      lane_vld <= 1'b0;
      lane_ph <= 1'b0;
    end else begin
      ser_word <= next_ser_word;
      ser_busy <= next_ser_busy;
      lane <= next_lane;
      lane_vld <= next_lane_vld;
      lane_ph <= next_lane_ph;
    end
  end

  assign dout_o = lane;
  assign dout_valid_o = lane_vld;
  assign dout_phase_o = lane_ph;
endmodule : qadc_top

// ---- qadc_pkg.sv ----
// Constants, register map and types of the quad converter configuration block
package qadc_pkg;
  // Converter shape
  localparam int NUM_CHAN = 4;
  localparam int RES_BITS = 11;
  localparam int HALF_BITS = 6;
  localparam int WORD_BITS = NUM_CHAN * RES_BITS;
  localparam int LANE_BITS = NUM_CHAN * HALF_BITS;
  // Latency in sample clocks
  localparam int LATENCY_CYC = 10;
  // Serial frame: read flag, eight address bits, eight data bits
  localparam int FRAME_BITS = 17;
  localparam logic [4:0] FRAME_LAST = 5'h11;
  localparam logic [4:0] ADDR_DONE = 5'h09;
  // Register offsets
  localparam logic [7:0] ADDR_SRC_SEL = 8'hEA;
  localparam logic [7:0] ADDR_PWR = 8'hFE;
  localparam logic [7:0] ADDR_TRIM14 = 8'h4A;
  localparam logic [7:0] ADDR_TRIM15 = 8'h62;
  localparam logic [7:0] ADDR_TRIM16 = 8'h92;
  localparam logic [7:0] ADDR_TRIM17 = 8'h7A;
  localparam logic [7:0] ADDR_ENH_DIS = 8'hE9;
  // Field positions
  localparam int SRC_SEL_BIT = 7;
  localparam int TRIM_BIT = 0;
  localparam int ENH_DIS_BIT = 0;
  localparam int PWR_D_BIT = 3;
  localparam int PWR_C_BIT = 2;
  localparam int PWR_B_BIT = 1;
  localparam int PWR_A_BIT = 0;
  // Reset values
  localparam logic [7:0] REG_RESET = 8'h00;
  // Serial slave states
  typedef enum logic [2:0] {
    QADC_S_IDLE = 3'b001,
    QADC_S_SHIFT = 3'b010,
    QADC_S_DONE = 3'b100
  } qadc_spi_state_t;
endpackage : qadc_pkg

// ---- qadc_reg_if.sv ----
// Register access interface between the serial slave and the register bank
`timescale 1ns/1ps
interface qadc_reg_if;
  logic wr; // One-cycle write strobe
  logic [7:0] addr; // Register offset
  logic [7:0] wdata; // Write data
  logic [7:0] rdata; // Read data for addr
  modport master (output wr, output addr, output wdata, input rdata);
  modport slave (input wr, input addr, input wdata, output rdata);
endinterface : qadc_reg_if

// ---- qadc_spi.sv ----
// Serial configuration slave, sclk sampled on the system clock
`timescale 1ns/1ps
module qadc_spi (
  // Clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // Serial pins
  input wire logic sen_n_i,
  input wire logic sclk_i,
  input wire logic sdata_i,
  output logic sdout_o,
  output logic sdout_oe_o,
  // Register side
  qadc_reg_if.master bus
);
  import qadc_pkg::*;

  qadc_spi_state_t state, next_state; // Frame state
  logic sclk_q, next_sclk_q; // Previous sclk level
  logic [4:0] cnt, next_cnt; // Bits taken this frame
  logic [15:0] shreg, next_shreg; // Incoming bits
  logic rd, next_rd; // Frame is a read
  logic [7:0] addr, next_addr; // Latched address
  logic [7:0] rd_sh, next_rd_sh; // Outgoing read data
  logic sdout, next_sdout; // Read data pin
  logic rise, fall; // sclk edges

  assign rise = sclk_i & ~sclk_q;
  assign fall = ~sclk_i & sclk_q;

  // Next-state logic for the frame
  always_comb begin
    next_state = state;
    next_sclk_q = sclk_i;
    next_cnt = cnt;
    next_shreg = shreg;
    next_rd = rd;
    next_addr = addr;
    next_rd_sh = rd_sh;
    next_sdout = sdout;
    case (state)
      QADC_S_IDLE: begin
        next_cnt = 5'h00;
        if (!sen_n_i) begin
          next_state = QADC_S_SHIFT;
        end
      end
      QADC_S_SHIFT: begin
        if (sen_n_i) begin
          // Short frame is dropped, no write happens
          next_state = QADC_S_IDLE;
        end else if (rise) begin
          next_shreg = {shreg[14:0], sdata_i};
          next_cnt = cnt + 5'h01;
          if (cnt == 5'h00) begin
            next_rd = sdata_i;
          end
          if (cnt == ADDR_DONE - 5'h01) begin
            next_addr = {shreg[6:0], sdata_i};
          end
          if (cnt == FRAME_LAST - 5'h01) begin
            next_state = QADC_S_DONE;
          end
        end else if (fall && rd && cnt == ADDR_DONE) begin
          // First read bit leaves on the falling edge after the address
          next_sdout = bus.rdata[7];
          next_rd_sh = {bus.rdata[6:0], 1'b0};
        end else if (fall && rd && cnt > ADDR_DONE) begin
          next_sdout = rd_sh[7];
          next_rd_sh = {rd_sh[6:0], 1'b0};
        end
      end
      QADC_S_DONE: begin
        // Wait for sen to rise before the next frame
        if (sen_n_i) begin
          next_state = QADC_S_IDLE;
        end
      end
      default: begin
        next_state = QADC_S_IDLE;
      end
    endcase
  end

  // Frame registers
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      state <= QADC_S_IDLE;
      sclk_q <= 1'b0;
      cnt <= 5'h00;
      shreg <= 16'h0000;
      rd <= 1'b0;
      addr <= 8'h00;
      rd_sh <= 8'h00;
      sdout <= 1'b0;
    end else begin
      state <= next_state;
      sclk_q <= next_sclk_q;
      cnt <= next_cnt;
      shreg <= next_shreg;
      rd <= next_rd;
      addr <= next_addr;
      rd_sh <= next_rd_sh;
      sdout <= next_sdout;
    end
  end

  // Write strobe one cycle as the frame completes
  assign bus.wr = (state == QADC_S_SHIFT) && rise && !sen_n_i && (cnt == FRAME_LAST - 5'h01) && !rd;
  assign bus.addr = addr;
  assign bus.wdata = {shreg[6:0], sdata_i};
  assign sdout_o = sdout;
  assign sdout_oe_o = (state == QADC_S_SHIFT) && rd && (cnt >= ADDR_DONE) && !sen_n_i;
endmodule : qadc_spi

// ---- qadc_buf.sv ----
// Two-entry buffer with valid and ready on both sides
`timescale 1ns/1ps
module qadc_buf (
  // Clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // Filling side
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [qadc_pkg::WORD_BITS-1:0] in_data_i,
  // Draining side
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [qadc_pkg::WORD_BITS-1:0] out_data_o
);
  import qadc_pkg::*;

  logic [WORD_BITS-1:0] mem [2]; // Storage
  logic [WORD_BITS-1:0] next_mem [2];
  logic wp, next_wp; // Write index
  logic rp, next_rp; // Read index
  logic [1:0] cnt, next_cnt; // Entries held
  logic push, pop;

  assign in_ready_o = (cnt != 2'h2);
  assign out_valid_o = (cnt != 2'h0);
  assign out_data_o = mem[rp];
  assign push = in_valid_i & in_ready_o;
  assign pop = out_valid_o & out_ready_i;

  // Pointer and storage update
  always_comb begin
    next_mem = mem;
    next_wp = wp;
    next_rp = rp;
    next_cnt = cnt;
    if (push) begin
      next_mem[wp] = in_data_i;
      next_wp = ~wp;
    end
    if (pop) begin
      next_rp = ~rp;
    end
    if (push && !pop) begin
      next_cnt = cnt + 2'h1;
    end else if (pop && !push) begin
      next_cnt = cnt - 2'h1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      mem[0] <= '0;
      mem[1] <= '0;
      wp <= 1'b0;
      rp <= 1'b0;
      cnt <= 2'h0;
    end else begin
      mem <= next_mem;
      wp <= next_wp;
      rp <= next_rp;
      cnt <= next_cnt;
    end
  end
endmodule : qadc_buf

// ---- qadc_top_sva.sv ----
// Port-level assertions for the quad converter configuration block
`timescale 1ns/1ps
module qadc_top_sva (
  // Clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // Serial pins
  input wire logic sen_n_i,
  input wire logic sclk_i,
  input wire logic sdata_i,
  input wire logic sdout_o,
  input wire logic sdout_oe_o,
  // Pin and controls
  input wire logic enhance_select_pin_i,
  input wire logic [qadc_pkg::WORD_BITS-1:0] core_code_i,
  input wire logic enhance_en_o,
  input wire logic [qadc_pkg::NUM_CHAN-1:0] power_off_o,
  input wire logic [3:0] low_clock_trim_group_o,
  // Lanes
  input wire logic [qadc_pkg::LANE_BITS-1:0] dout_o,
  input wire logic dout_valid_o,
  input wire logic dout_phase_o,
  input wire logic rx_ready_i
);
  import qadc_pkg::*;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  logic [5:0] since_rst; // Cycles since release, saturates
  logic [5:0] next_since_rst; // Next count
  // Count cycles after reset release
  always_comb begin
    next_since_rst = since_rst;
    if (!nrst_i) begin
      next_since_rst = 6'h00;
    end else if (since_rst != 6'h3F) begin
      next_since_rst = since_rst + 6'h01;
    end
  end
  // Register the count
  always_ff @(posedge clk_i) begin
    since_rst <= next_since_rst;
  end
  // Halves of one word on the lanes
  sequence s_even;
    dout_valid_o && !dout_phase_o && rx_ready_i;
  endsequence
  sequence s_odd;
    dout_valid_o && dout_phase_o;
  endsequence
  AST_RST_CLEAR: assert property ($rose(nrst_i) |-> power_off_o == 4'h0 && low_clock_trim_group_o == 4'h0
    && !dout_valid_o) else $error("outputs not cleared by reset");
  AST_RST_PIN: assert property ($rose(nrst_i) |-> enhance_en_o == enhance_select_pin_i)
    else $error("enhancement not on pin after reset");
  AST_PWR_QUIET: assert property ($past(nrst_i) && sen_n_i && $past(sen_n_i) |-> $stable(power_off_o))
    else $error("power-down changed outside a frame");
  AST_TRIM_QUIET: assert property ($past(nrst_i) && sen_n_i && $past(sen_n_i)
    |-> $stable(low_clock_trim_group_o)) else $error("trim changed outside a frame");
  AST_OE_IDLE: assert property (sen_n_i |-> !sdout_oe_o) else $error("read line driven while idle");
  AST_HALF_PAIR: assert property (s_even |=> s_odd) else $error("odd half missing");
  AST_ODD_PAD: assert property (s_odd |-> !dout_o[5] && !dout_o[11] && !dout_o[17] && !dout_o[23])
    else $error("odd half pad bit set");
  AST_FIRST_WORD: assert property (dout_valid_o |-> since_rst >= 6'h14) else $error("word before latency");
  AST_ODD_GAP: assert property (s_odd |=> !(dout_valid_o && dout_phase_o))
    else $error("two odd halves in a row");
endmodule : qadc_top_sva

bind qadc_top qadc_top_sva u_qadc_top_sva (.clk_i(clk_i), .nrst_i(nrst_i), .sen_n_i(sen_n_i), .sclk_i(sclk_i),
  .sdata_i(sdata_i), .sdout_o(sdout_o), .sdout_oe_o(sdout_oe_o), .enhance_select_pin_i(enhance_select_pin_i),
  .core_code_i(core_code_i), .enhance_en_o(enhance_en_o), .power_off_o(power_off_o),
  .low_clock_trim_group_o(low_clock_trim_group_o), .dout_o(dout_o), .dout_valid_o(dout_valid_o),
  .dout_phase_o(dout_phase_o), .rx_ready_i(rx_ready_i));

// ---- qadc_host_model.sv ----
// Host serial master and double-rate lane receiver model
`timescale 1ns/1ps
module qadc_host_model (
  // Clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // Serial pins
  output logic sen_n_o,
  output logic sclk_o,
  output logic sdata_o,
  input wire logic sdout_i,
  input wire logic sdout_oe_i,
  // Lanes
  input wire logic [qadc_pkg::LANE_BITS-1:0] dout_i,
  input wire logic dout_valid_i,
  input wire logic dout_phase_i,
  output logic rx_ready_o
);
  import qadc_pkg::*;
  logic stall = 1'b0; // Random back-pressure when set
  int seed = 99049; // Fixed seed for ready pattern
  logic [WORD_BITS-1:0] last_word = '0; // Last rebuilt word
  logic [LANE_BITS-1:0] even_half = '0; // Held even half
  // Idle pins at time zero
  initial begin
    sen_n_o = 1'b1;
    sclk_o = 1'b0;
    sdata_o = 1'b0;
    rx_ready_o = 1'b1;
  end
  // Take halves and rebuild words; ready wanders only while stalling
  // A half already launched is taken even if ready has just dropped
  always @(posedge clk_i) begin
    rx_ready_o <= #1 stall ? 1'($random(seed)) : 1'b1;
    if (nrst_i && dout_valid_i) begin
      if (!dout_phase_i) begin
        even_half <= dout_i;
      end else begin
        for (int c = 0; c < NUM_CHAN; c++) begin
          for (int j = 0; j < RES_BITS; j++) begin
            last_word[c*RES_BITS+j] <= j[0] ? dout_i[c*HALF_BITS+j/2] : even_half[c*HALF_BITS+j/2];
          end
        end
      end
    end
  end
  // One frame; fewer than all bits aborts it. Slow phases of 4 clocks
  task automatic xfer(input logic rd, input logic [7:0] addr, input logic [7:0] wd, input int nbits,
                      output logic [7:0] rdv);
    logic [16:0] frame;
    frame = {rd, addr, rd ? 8'h00 : wd};
    rdv = 8'h00;
    sen_n_o = 1'b0;
    for (int i = 0; i < nbits; i++) begin
      sdata_o = frame[16-i];
      repeat (4) @(posedge clk_i);
      #1;
      if (i > 8 && sdout_oe_i === 1'b1) rdv[16-i] = sdout_i;
      sclk_o = 1'b1;
      repeat (4) @(posedge clk_i);
      #1 sclk_o = 1'b0;
    end
    repeat (4) @(posedge clk_i);
    #1 sen_n_o = 1'b1;
    sdata_o = ~sdata_o; // Released line shows no stale bit
    repeat (3) @(posedge clk_i);
    #1;
  endtask : xfer
endmodule : qadc_host_model

// ---- tb_top.sv ----
// Self-checking testbench for the quad converter configuration block
`timescale 1ns/1ps
module tb_top;
  import qadc_pkg::*;
  logic clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic enhance_select_pin_i = 1'b0;
  logic [WORD_BITS-1:0] core_code_i = '0;
  logic sen_n_i, sclk_i, sdata_i, sdout_o, sdout_oe_o, enhance_en_o, dout_valid_o, dout_phase_o, rx_ready_i;
  logic [NUM_CHAN-1:0] power_off_o;
  logic [3:0] low_clock_trim_group_o;
  logic [LANE_BITS-1:0] dout_o;
  int bad_count = 0;
  int n_compared = 0;
  int cyc = 0;
  int t0;
  int seed = 99049;
  logic [7:0] rd;
  logic [WORD_BITS-1:0] v;
  logic [3:0] pwr;
  logic [7:0] addrs [6] = '{ADDR_SRC_SEL, ADDR_PWR, ADDR_TRIM14, ADDR_TRIM15, ADDR_TRIM16, ADDR_TRIM17};
  logic [15:0] tune [8] = '{16'hD480, 16'hD580, 16'hD680, 16'hD70C, 16'hDB30, 16'hF038, 16'hF120, 16'hF542};
  // 25 MHz clock
  always #20 clk_i = ~clk_i;
  qadc_top u_qadc_top (.clk_i, .nrst_i, .sen_n_i, .sclk_i, .sdata_i, .sdout_o, .sdout_oe_o, .enhance_select_pin_i,
    .core_code_i, .enhance_en_o, .power_off_o, .low_clock_trim_group_o, .dout_o, .dout_valid_o, .dout_phase_o,
    .rx_ready_i);
  qadc_host_model u_host (.clk_i(clk_i), .nrst_i(nrst_i), .sen_n_o(sen_n_i), .sclk_o(sclk_i), .sdata_o(sdata_i),
    .sdout_i(sdout_o), .sdout_oe_i(sdout_oe_o), .dout_i(dout_o), .dout_valid_i(dout_valid_o),
    .dout_phase_i(dout_phase_o), .rx_ready_o(rx_ready_i));
  // Hang guard, far above the expected run length
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      bad_count++;
      print_verdict();
    end
  end
  task automatic print_verdict;
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : print_verdict
  task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic step(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : step
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    u_host.xfer(1'b0, a, d, FRAME_BITS, rd);
  endtask : wr
  task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
    u_host.xfer(1'b1, a, 8'h00, FRAME_BITS, rd);
    check("read data", rd, e);
  endtask : rdchk
  // Expected lane word: sign bit flipped, stopped channels zero
  function automatic logic [WORD_BITS-1:0] conv(input logic [WORD_BITS-1:0] c, input logic [3:0] p);
    conv = c;
    for (int i = 0; i < NUM_CHAN; i++) begin
      conv[i*RES_BITS+RES_BITS-1] = ~c[i*RES_BITS+RES_BITS-1];
      if (p[i]) conv[i*RES_BITS +: RES_BITS] = '0;
    end
  endfunction : conv
  // Main sequence
  initial begin
    step(6);
    nrst_i = 1'b1;
    foreach (addrs[i]) rdchk(addrs[i], 8'h00);
    check("power", power_off_o, 4'h0);
    wr(ADDR_ENH_DIS, 8'h01);
    for (int m = 0; m < 4; m++) begin
      if (m == 2) wr(ADDR_SRC_SEL, 8'h80);
      enhance_select_pin_i = m[0];
      step(1);
      check("enhance", enhance_en_o, m[1] ? 1'b0 : m[0]);
    end
    enhance_select_pin_i = 1'b0;
    wr(ADDR_ENH_DIS, 8'h00);
    check("enhance", enhance_en_o, 1'b1);
    for (int b = 0; b < NUM_CHAN; b++) begin
      wr(ADDR_PWR, 8'h01 << b);
      check("power", power_off_o, 4'h1 << b);
      rdchk(ADDR_PWR, 8'h01 << b);
    end
    u_host.xfer(1'b0, ADDR_PWR, 8'h0F, 12, rd);
    check("power", power_off_o, 4'h8);
    for (int i = 2; i < 6; i++) wr(addrs[i], 8'h01);
    check("trim", low_clock_trim_group_o, 4'hF);
    foreach (tune[i]) wr(tune[i][15:8], tune[i][7:0]);
    check("power", power_off_o, 4'h8);
    rdchk(8'h33, 8'h00);
    for (int k = 0; k < 6; k++) begin
      v = WORD_BITS'({$random(seed), $random(seed)});
      pwr = (k == 0) ? 4'h0 : (k == 5) ? 4'hF : 4'($random(seed));
      wr(ADDR_PWR, {4'h0, pwr});
      core_code_i = v;
      u_host.stall = 1'b1;
      step(60);
      u_host.stall = 1'b0;
      step(40);
      check("word", u_host.last_word, conv(v, pwr));
    end
    wr(ADDR_PWR, 8'h00);
    v = ~v;
    core_code_i = v;
    t0 = cyc;
    while (u_host.last_word !== conv(v, 4'h0) && cyc < t0 + 40) step(1);
    check("latency", cyc - t0 >= 21 && cyc - t0 <= 27, 1'b1);
    nrst_i = 1'b0;
    step(3);
    nrst_i = 1'b1;
    check("trim", low_clock_trim_group_o, 4'h0);
    rdchk(ADDR_SRC_SEL, 8'h00);
    print_verdict();
  end
endmodule : tb_top
